// [src/pfto_pkg.sv]
// Purpose: Shared constants and types for the port fault timer block
// Assumes: 100 MHz clock, 8-bit register port, four ports
// Notes:   Timer unit is one microsecond tick
package pfto_pkg;

	localparam int          NUM_PORTS       = 4;
	localparam int          CLK_MHZ         = 100;
	localparam int          TICK_US         = 1;
	localparam int          TICK_CYCLES     = TICK_US * CLK_MHZ;
	localparam int          TICK_W          = 7;
	localparam int          DOWN_RATIO      = 16;
	localparam int          SC_RELEASE_US   = 100;
	localparam int          SC_W            = 16;
	localparam int          DUR_W           = 20;
	localparam int          OC_W            = 26;

	localparam logic [7:0]  ADDR_FAULT      = 8'h06;
	localparam logic [7:0]  ADDR_FAULT_COR  = 8'h07;
	localparam logic [7:0]  ADDR_TIMING     = 8'h16;
	localparam logic [7:0]  TIMING_RST      = 8'h00;
	localparam logic [7:0]  FAULT_RST       = 8'h00;
	localparam logic [7:0]  TIMING_MASK     = 8'h3F;
	localparam int          DIS_SEL_LSB     = 0;
	localparam int          OC_SEL_LSB      = 2;
	localparam int          START_SEL_LSB   = 4;
	localparam int          FAULT_OC_LSB    = 0;
	localparam int          FAULT_START_LSB = 4;

	localparam logic [1:0]  MODE_SHUTDOWN   = 2'h0;
	localparam logic [1:0]  MODE_MANUAL     = 2'h1;
	localparam logic [1:0]  MODE_SEMIAUTO   = 2'h2;
	localparam logic [1:0]  MODE_AUTO       = 2'h3;

	typedef enum logic [4:0] {
		ST_IDLE     = 5'h01,
		ST_DETECT   = 5'h02,
		ST_STARTUP  = 5'h04,
		ST_POWERED  = 5'h08,
		ST_COOLDOWN = 5'h10
	} pfto_state_t;

	typedef struct packed {
		logic short_circuit;
		logic current_limit;
		logic overcurrent;
		logic power_good;
	} pfto_sense_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pfto_reg_req_t;

endpackage

// [src/pfto_port_fault_timers.sv]
// Purpose: Per-port overcurrent, start-up and short-circuit fault timing
// Assumes: Comparator inputs are asynchronous; commands come from same-clock logic
// Notes:   Durations per timing code are parameters; one microsecond timer tick
`timescale 1ns/1ps
module pfto_port_fault_timers #(
	parameter logic [3:0][pfto_pkg::DUR_W-1:0] OC_TIME_US =
		{20'h3A980, 20'h1D4C0, 20'h0EA60, 20'h07530},
	parameter logic [3:0][pfto_pkg::DUR_W-1:0] START_TIME_US =
		{20'h3A980, 20'h1D4C0, 20'h0EA60, 20'h07530},
	parameter int SC_RELEASE_CYCLES = pfto_pkg::SC_RELEASE_US * pfto_pkg::CLK_MHZ
) (
	input  wire logic                                          clock_i,
	input  wire logic                                          nrst_i,
	input  wire pfto_pkg::pfto_sense_t [pfto_pkg::NUM_PORTS-1:0] sense_i,
	input  wire logic [pfto_pkg::NUM_PORTS-1:0][1:0]           port_mode_i,
	input  wire logic [pfto_pkg::NUM_PORTS-1:0]                power_on_cmd_i,
	input  wire logic [pfto_pkg::NUM_PORTS-1:0]                restart_detect_i,
	input  wire logic [pfto_pkg::NUM_PORTS-1:0]                detect_done_i,
	input  wire logic [pfto_pkg::NUM_PORTS-1:0]                detect_good_i,
	input  wire logic [pfto_pkg::NUM_PORTS-1:0]                disconnect_off_i,
	input  wire pfto_pkg::pfto_reg_req_t                       reg_req_i,
	output logic [7:0]                                         reg_rdata_o,
	output logic [1:0]                                         disconnect_time_sel_o,
	output logic [pfto_pkg::NUM_PORTS-1:0]                     gate_on_o,
	output logic [pfto_pkg::NUM_PORTS-1:0]                     gate_pulldown_o,
	output logic [pfto_pkg::NUM_PORTS-1:0]                     detect_req_o,
	output logic [pfto_pkg::NUM_PORTS-1:0]                     disconnect_arm_o,
	output logic [pfto_pkg::NUM_PORTS-1:0]                     oc_count_zero_o
);

	localparam int NP = pfto_pkg::NUM_PORTS;

	pfto_pkg::pfto_sense_t [NP-1:0] sense_meta_r;
	pfto_pkg::pfto_sense_t [NP-1:0] sense_s_r;
	logic [pfto_pkg::TICK_W-1:0]    tick_cnt_r;
	logic                           tick;
	logic [7:0]                     timing_r;
	logic [7:0]                     fault_r;
	logic [7:0]                     fault_nxt;
	logic [7:0]                     rdata_r;
	logic [NP-1:0]                  oc_fault_set;
	logic [NP-1:0]                  st_fault_set;
	logic [1:0]                     oc_sel;
	logic [1:0]                     st_sel;
	logic [pfto_pkg::OC_W-1:0]      oc_full;
	logic [pfto_pkg::OC_W-1:0]      st_full;
	logic [pfto_pkg::DUR_W-1:0]     st_dur;

	// Two-flop synchronisers for comparator pins
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sense_meta_r <= '0;
			sense_s_r    <= '0;
		end else begin
			sense_meta_r <= sense_i;
			sense_s_r    <= sense_meta_r;
		end
	end

	// Shared microsecond tick
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt_r <= '0;
		end else if (tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end
	assign tick = (tick_cnt_r == pfto_pkg::TICK_W'(pfto_pkg::TICK_CYCLES - 1));

	// Timing code decode, shared by all ports
	assign oc_sel  = timing_r[pfto_pkg::OC_SEL_LSB +: 2];
	assign st_sel  = timing_r[pfto_pkg::START_SEL_LSB +: 2];
	assign st_dur  = START_TIME_US[st_sel];
	// Full counts scaled so a count-down step of one is the slow rate
	assign oc_full = pfto_pkg::OC_W'(OC_TIME_US[oc_sel]) *
		pfto_pkg::OC_W'(pfto_pkg::DOWN_RATIO);
	assign st_full = pfto_pkg::OC_W'(st_dur) * pfto_pkg::OC_W'(pfto_pkg::DOWN_RATIO);
	assign disconnect_time_sel_o = timing_r[pfto_pkg::DIS_SEL_LSB +: 2];

	// Timing configuration register
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timing_r <= pfto_pkg::TIMING_RST;
		end else if (reg_req_i.wr && reg_req_i.addr == pfto_pkg::ADDR_TIMING) begin
			timing_r <= reg_req_i.wdata & pfto_pkg::TIMING_MASK;
		end
	end

	// Fault events; a set in the clearing read's cycle survives it
	always_comb begin
		fault_nxt = fault_r;
		if (reg_req_i.rd && reg_req_i.addr == pfto_pkg::ADDR_FAULT_COR) begin
			fault_nxt = pfto_pkg::FAULT_RST;
		end
		fault_nxt[pfto_pkg::FAULT_OC_LSB +: NP]    =
			fault_nxt[pfto_pkg::FAULT_OC_LSB +: NP] | oc_fault_set;
		fault_nxt[pfto_pkg::FAULT_START_LSB +: NP] =
			fault_nxt[pfto_pkg::FAULT_START_LSB +: NP] | st_fault_set;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_r <= pfto_pkg::FAULT_RST;
		end else begin
			fault_r <= fault_nxt;
		end
	end

	// Read data held until the next read
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_r <= '0;
		end else if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				pfto_pkg::ADDR_FAULT:     rdata_r <= fault_r;
				pfto_pkg::ADDR_FAULT_COR: rdata_r <= fault_r;
				pfto_pkg::ADDR_TIMING:    rdata_r <= timing_r;
				default:                  rdata_r <= '0;
			endcase
		end
	end
	assign reg_rdata_o = rdata_r;

	genvar p;
	generate
		for (p = 0; p < NP; p++) begin : g_port
			pfto_pkg::pfto_state_t      state_r;
			pfto_pkg::pfto_state_t      state_nxt;
			logic [pfto_pkg::OC_W-1:0]  oc_cnt_r;
			logic [pfto_pkg::DUR_W-1:0] st_cnt_r;
			logic [pfto_pkg::SC_W-1:0]  sc_cnt_r;
			logic                       cl_all_r;
			logic                       gate_r;
			logic                       pd_r;
			logic                       up_cond;
			logic                       in_start;
			logic                       oc_expired;
			logic                       st_expired;
			logic                       st_cl_fault;
			logic                       cmd_ok;
			logic [pfto_pkg::OC_W-1:0]  limit;
			logic [pfto_pkg::OC_W:0]    up_sum;

			assign in_start   = (state_r == pfto_pkg::ST_STARTUP);
			// Overcurrent or high output, including foldback operation
			assign up_cond    = gate_r &&
				(sense_s_r[p].overcurrent || sense_s_r[p].power_good);
			assign limit      = in_start ? st_full : oc_full;
			assign oc_expired = gate_r && (oc_cnt_r >= limit);
			assign st_expired = in_start && tick && (st_cnt_r >= st_dur);
			assign st_cl_fault = st_expired && cl_all_r && sense_s_r[p].current_limit;
			assign up_sum     = {1'b0, oc_cnt_r} +
				(pfto_pkg::OC_W + 1)'(pfto_pkg::DOWN_RATIO);
			// Host power command only honoured once the count is back at zero
			assign cmd_ok     = power_on_cmd_i[p] && (oc_cnt_r == '0) &&
				(port_mode_i[p] == pfto_pkg::MODE_MANUAL ||
				 port_mode_i[p] == pfto_pkg::MODE_SEMIAUTO);

			// Up/down duty-cycle counter
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					oc_cnt_r <= '0;
				end else if (tick) begin
					if (up_cond) begin
						oc_cnt_r <= (up_sum > {1'b0, limit}) ? limit :
							up_sum[pfto_pkg::OC_W-1:0];
					end else if (oc_cnt_r != '0) begin
						oc_cnt_r <= oc_cnt_r - 1'b1;
					end
				end
			end

			// Start-up timer and whole-period current limit tracking
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					st_cnt_r <= '0;
					cl_all_r <= 1'b0;
				end else if (state_r != pfto_pkg::ST_STARTUP &&
						state_nxt == pfto_pkg::ST_STARTUP) begin
					st_cnt_r <= '0;
					cl_all_r <= 1'b1;
				end else if (in_start && tick) begin
					st_cnt_r <= st_cnt_r + 1'b1;
					cl_all_r <= cl_all_r && sense_s_r[p].current_limit;
				end
			end

			always_comb begin
				state_nxt = state_r;
				unique case (state_r)
					pfto_pkg::ST_IDLE: begin
						if (cmd_ok) begin
							state_nxt = pfto_pkg::ST_STARTUP;
						end else if (port_mode_i[p] == pfto_pkg::MODE_MANUAL) begin
							if (restart_detect_i[p]) begin
								state_nxt = pfto_pkg::ST_DETECT;
							end
						end else if (port_mode_i[p] != pfto_pkg::MODE_SHUTDOWN) begin
							state_nxt = pfto_pkg::ST_DETECT;
						end
					end
					pfto_pkg::ST_DETECT: begin
						if (port_mode_i[p] == pfto_pkg::MODE_SHUTDOWN) begin
							state_nxt = pfto_pkg::ST_IDLE;
						end else if (cmd_ok) begin
							state_nxt = pfto_pkg::ST_STARTUP;
						end else if (detect_done_i[p]) begin
							// Detection only starts from idle, whatever the count
							if (port_mode_i[p] == pfto_pkg::MODE_AUTO &&
									detect_good_i[p]) begin
								state_nxt = pfto_pkg::ST_STARTUP;
							end else begin
								state_nxt = pfto_pkg::ST_IDLE;
							end
						end
					end
					pfto_pkg::ST_STARTUP: begin
						if (oc_expired || st_cl_fault) begin
							state_nxt = pfto_pkg::ST_COOLDOWN;
						end else if (disconnect_off_i[p] ||
								port_mode_i[p] == pfto_pkg::MODE_SHUTDOWN) begin
							state_nxt = pfto_pkg::ST_IDLE;
						end else if (st_expired) begin
							state_nxt = pfto_pkg::ST_POWERED;
						end
					end
					pfto_pkg::ST_POWERED: begin
						if (oc_expired) begin
							state_nxt = pfto_pkg::ST_COOLDOWN;
						end else if (disconnect_off_i[p] ||
								port_mode_i[p] == pfto_pkg::MODE_SHUTDOWN) begin
							state_nxt = pfto_pkg::ST_IDLE;
						end
					end
					pfto_pkg::ST_COOLDOWN: begin
						if (oc_cnt_r == '0) begin
							state_nxt = pfto_pkg::ST_IDLE;
						end
					end
					default: begin
						state_nxt = pfto_pkg::ST_IDLE;
					end
				endcase
			end

			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					state_r <= pfto_pkg::ST_IDLE;
				end else begin
					state_r <= state_nxt;
				end
			end

			// Fault pulses; start-up period faults are reported as start-up
			assign oc_fault_set[p] = oc_expired && !in_start;
			assign st_fault_set[p] = in_start && (oc_expired || st_cl_fault);

			// Gate enable dropped the same edge the state leaves power
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					gate_r <= 1'b0;
				end else begin
					gate_r <= (state_nxt == pfto_pkg::ST_STARTUP) ||
						(state_nxt == pfto_pkg::ST_POWERED);
				end
			end

			// Short-circuit pulldown, released after a fixed hold
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					sc_cnt_r <= '0;
					pd_r     <= 1'b0;
				end else if (sc_cnt_r == '0 && gate_r && sense_s_r[p].short_circuit) begin
					sc_cnt_r <= pfto_pkg::SC_W'(SC_RELEASE_CYCLES - 1);
					pd_r     <= 1'b1;
				end else if (sc_cnt_r != '0) begin
					sc_cnt_r <= sc_cnt_r - 1'b1;
					pd_r     <= 1'b1;
				end else begin
					pd_r     <= 1'b0;
				end
			end

			assign gate_on_o[p]        = gate_r && !pd_r;
			assign gate_pulldown_o[p]  = pd_r;
			assign detect_req_o[p]     = (state_r == pfto_pkg::ST_DETECT);
			assign disconnect_arm_o[p] = (state_r == pfto_pkg::ST_POWERED);
			assign oc_count_zero_o[p]  = (oc_cnt_r == '0);
		end
	endgenerate

endmodule

// [dv/pfto_assertions.sv]
// Purpose: Concurrent checks on port 0 of the fault timer block
// Assumes: Port 0 stands for four identical port slices
// Notes:   Sees only top-level ports; bound below
`timescale 1ns/1ps
module pfto_assertions #(
	parameter int SC_RELEASE_CYCLES = 10000
) (
	input wire logic                        clock_i,
	input wire logic                        nrst_i,
	input wire pfto_pkg::pfto_sense_t [3:0] sense_i,
	input wire pfto_pkg::pfto_reg_req_t     reg_req_i,
	input wire logic [7:0]                  reg_rdata_o,
	input wire logic [1:0]                  disconnect_time_sel_o,
	input wire logic [3:0]                  gate_on_o,
	input wire logic [3:0]                  gate_pulldown_o,
	input wire logic [3:0]                  disconnect_arm_o,
	input wire logic [3:0]                  oc_count_zero_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	logic [15:0] pd_cnt_r;
	logic [15:0] on_cnt_r;
	// Counters, since repetition past eight cycles is not allowed
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pd_cnt_r <= 16'h0000;
			on_cnt_r <= 16'h0000;
		end else begin
			pd_cnt_r <= gate_pulldown_o[0] ? pd_cnt_r + 16'h0001 : 16'h0000;
			on_cnt_r <= (gate_on_o[0] || gate_pulldown_o[0]) ? on_cnt_r + 16'h0001 : 16'h0000;
		end
	end
	gate_exclusive_a: assert property (!(gate_on_o[0] && gate_pulldown_o[0]))
		else $error("pull-up and fast pulldown both active");
	short_pull_a: assert property ((sense_i[0].short_circuit && gate_on_o[0])[*3]
		|-> ##[0:1] gate_pulldown_o[0]) else $error("short not pulled down");
	release_time_a: assert property ($fell(gate_pulldown_o[0]) |->
		pd_cnt_r >= SC_RELEASE_CYCLES - 1 && pd_cnt_r <= SC_RELEASE_CYCLES + 1)
		else $error("pulldown release time wrong");
	repower_zero_a: assert property ($rose(gate_on_o[0]) && !$past(gate_pulldown_o[0])
		|-> $past(oc_count_zero_o[0])) else $error("repower with count above zero");
	idle_hold_a: assert property (!gate_on_o[0] && !gate_pulldown_o[0] && oc_count_zero_o[0]
		|=> oc_count_zero_o[0]) else $error("count left zero while port off");
	arm_delay_a: assert property ($rose(disconnect_arm_o[0]) |-> on_cnt_r >= 16'h0064)
		else $error("disconnect armed before start-up ended");
	arm_gate_a: assert property (disconnect_arm_o[0] |-> gate_on_o[0] || gate_pulldown_o[0])
		else $error("disconnect armed on unpowered port");
	timing_read_a: assert property (reg_req_i.rd && reg_req_i.addr == 8'h16 |=>
		reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[1:0] == disconnect_time_sel_o)
		else $error("timing read data wrong");
endmodule

bind pfto_port_fault_timers pfto_assertions #(
	.SC_RELEASE_CYCLES(SC_RELEASE_CYCLES)
) u_chk (
	.clock_i(clock_i), .nrst_i(nrst_i), .sense_i(sense_i), .reg_req_i(reg_req_i),
	.reg_rdata_o(reg_rdata_o), .disconnect_time_sel_o(disconnect_time_sel_o),
	.gate_on_o(gate_on_o), .gate_pulldown_o(gate_pulldown_o),
	.disconnect_arm_o(disconnect_arm_o), .oc_count_zero_o(oc_count_zero_o)
);

// [dv/pfto_port_model.sv]
// Purpose: FET, sense resistor and load model for four ports
// Assumes: Load codes 0 light, 1 overload, 2 short, 3 high output
// Notes:   Comparators follow the gate with no analog delay
`timescale 1ns/1ps
module pfto_port_model (
	input  wire logic [3:0]            gate_on_i,
	input  wire logic [3:0][1:0]       load_i,
	output pfto_pkg::pfto_sense_t [3:0] sense_o
);
	// A FET that is off carries no current, so every comparator reads low
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			sense_o[p] = {gate_on_i[p] && load_i[p] == 2'h2, gate_on_i[p] && load_i[p] == 2'h1,
				gate_on_i[p] && load_i[p] == 2'h1, gate_on_i[p] && load_i[p] == 2'h3};
		end
	end
endmodule

// [dv/tb_pfto_port_fault_timers.sv]
// Purpose: Self-checking bench for the port fault timer block
// Assumes: Short durations per timing code; one microsecond tick
// Notes:   Register reads checked through an expectation queue
`timescale 1ns/1ps
module tb_pfto_port_fault_timers;
	localparam int SC = 20;
	logic                        clock_i = 1'b0;
	logic                        nrst_i = 1'b0;
	pfto_pkg::pfto_sense_t [3:0] sense;
	pfto_pkg::pfto_reg_req_t     req = '0;
	logic [3:0][1:0]             mode = '0, load = '0;
	logic [3:0]                  pwr = '0, rst_det = '0, done = '0, doff = '0, good = 4'hF;
	logic [3:0]                  gate, pd, dreq, arm, zero;
	logic [7:0]                  rdata, cfg;
	logic [1:0]                  dsel;
	logic [7:0]                  exp_q[$];
	logic                        rd_seen = 1'b0;
	int                          errors = 0, n_compared = 0, seed = 53, a, b;

	always #5 clock_i = ~clock_i;

	pfto_port_fault_timers #(
		.OC_TIME_US       ({20'h0000C, 20'h0000A, 20'h00008, 20'h00006}),
		.START_TIME_US    ({20'h00007, 20'h00005, 20'h00004, 20'h00003}),
		.SC_RELEASE_CYCLES(SC)
	) u_dut (
		.clock_i(clock_i), .nrst_i(nrst_i), .sense_i(sense), .port_mode_i(mode),
		.power_on_cmd_i(pwr), .restart_detect_i(rst_det), .detect_done_i(done),
		.detect_good_i(good), .disconnect_off_i(doff), .reg_req_i(req),
		.reg_rdata_o(rdata), .disconnect_time_sel_o(dsel), .gate_on_o(gate),
		.gate_pulldown_o(pd), .detect_req_o(dreq), .disconnect_arm_o(arm),
		.oc_count_zero_o(zero)
	);
	pfto_port_model u_model (.gate_on_i(gate), .load_i(load), .sense_o(sense));

	task automatic step(input int n = 1);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic reg_op(input logic rd, input logic [7:0] addr, input logic [7:0] val);
		if (rd) exp_q.push_back(val);
		step();
		req = '{rd: rd, wr: !rd, addr: addr, wdata: val};
		step();
		req = '0;
	endtask
	task automatic pulse(input int k, input logic [3:0] m);
		if (k == 0) pwr = m;
		else if (k == 1) rst_det = m;
		else if (k == 2) done = m;
		else doff = m;
		step();
		{pwr, rst_det, done, doff} = '0;
	endtask
	// Selects: 0 gate, 1 detect, 2 count zero, 3 armed, 4 pulldown
	task automatic wait_on(input int s, input int p, input logic lvl, input int max, output int c);
		logic [4:0] v;
		c = 0;
		v = {pd[p], arm[p], zero[p], dreq[p], gate[p]};
		while (v[s] !== lvl) begin
			step();
			c++;
			v = {pd[p], arm[p], zero[p], dreq[p], gate[p]};
			if (c > max) begin
				errors++;
				$display("ERROR wait %0d port %0d expected %0b seen timeout", s, p, lvl);
				tally_and_finish();
			end
		end
	endtask

	// Read data settles one edge after the request; sample clear of that edge
	always @(posedge clock_i) begin
		rd_seen <= req.rd;
		if (rd_seen) begin
			#2;
			check("read data", rdata, exp_q.pop_front());
		end
	end

	initial begin
		repeat (4) @(posedge clock_i);
		#1;
		nrst_i = 1'b1;
		check("count zero", zero, 4'hF);
		check("gate", {gate, pd}, 8'h00);
		reg_op(1, 8'h16, 8'h00);
		cfg = 8'($random(seed));
		reg_op(0, 8'h16, cfg);
		reg_op(1, 8'h16, cfg & 8'h3F);
		check("disconnect select", dsel, cfg[1:0]);
		reg_op(0, 8'h06, 8'hFF);
		reg_op(1, 8'h06, 8'h00);
		reg_op(1, 8'h42, 8'h00);
		reg_op(0, 8'h16, 8'h2C);
		load[1] = 2'h1;
		mode = {2'h3, 2'h0, 2'h3, 2'h3};
		wait_on(1, 0, 1'b1, 10, a);
		pulse(2, 4'hB);
		wait_on(0, 0, 1'b1, 5, a);
		wait_on(0, 1, 1'b0, 800, a);
		check("start fault time", a inside {[400:700]}, 1);
		wait_on(3, 0, 1'b1, 800, b);
		check("arm time", (a + b) inside {[400:700]}, 1);
		reg_op(1, 8'h06, 8'h20);
		load[0] = 2'h1;
		load[3] = 2'h3;
		wait_on(0, 0, 1'b0, 1500, a);
		check("expiry time", a inside {[1050:1350]}, 1);
		wait_on(0, 3, 1'b0, 300, a);
		reg_op(1, 8'h07, 8'h29);
		reg_op(1, 8'h07, 8'h00);
		load = '0;
		check("no repower", {gate[0], dreq[0], zero[0]}, 3'h0);
		mode[1] = 2'h1;
		pulse(0, 4'h2);
		step(3);
		check("refused power", gate[1], 1'b0);
		wait_on(2, 1, 1'b1, 9000, a);
		// Cooldown leaves for idle one edge after the count reaches zero
		step();
		mode[2] = 2'h2;
		pulse(1, 4'h2);
		wait_on(1, 1, 1'b1, 5, a);
		wait_on(1, 2, 1'b1, 5, a);
		pulse(2, 4'h6);
		step(3);
		check("manual idle", {dreq[1], gate[1]}, 2'h0);
		check("semiauto waits", gate[2], 1'b0);
		pulse(0, 4'h6);
		wait_on(0, 1, 1'b1, 5, a);
		wait_on(0, 2, 1'b1, 5, a);
		wait_on(3, 1, 1'b1, 800, a);
		pulse(3, 4'h2);
		check("disconnect off", {gate[1], arm[1]}, 2'h0);
		reg_op(1, 8'h07, 8'h00);
		wait_on(2, 0, 1'b1, 20000, a);
		wait_on(1, 0, 1'b1, 5, a);
		check("no auto power", gate[0], 1'b0);
		good = 4'hE;
		pulse(2, 4'h1);
		check("failed detect", {gate[0], dreq[0]}, 2'h0);
		wait_on(1, 0, 1'b1, 5, a);
		good = 4'hF;
		pulse(2, 4'h1);
		wait_on(0, 0, 1'b1, 5, a);
		load[0] = 2'h2;
		wait_on(4, 0, 1'b1, 6, a);
		load[0] = 2'h0;
		check("gate in pulldown", gate[0], 1'b0);
		wait_on(4, 0, 1'b0, SC + 5, a);
		check("release time", a inside {[SC - 4:SC + 1]}, 1);
		wait_on(0, 0, 1'b1, 3, a);
		tally_and_finish();
	end
endmodule
